// ---- cfg_base_address_block.sv ----
// configuration header words for the window bases, unused slots and subsystem identity
`timescale 1ns/1ps
`default_nettype none
module cfg_base_address_block #(
    parameter int REG_LOG2 = cfg_header_pkg::REG_WINDOW_LOG2,
    parameter int ARR_LOG2 = cfg_header_pkg::ARRAY_WINDOW_LOG2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // shared bus pins
    input wire cfg_header_pkg::bus_in_t bus_in,
    output cfg_header_pkg::bus_out_t bus_out,
    // eeprom strap and identity load
    input wire logic external_eeprom_present,
    input wire logic subsys_load_valid,
    input wire logic [31:0] subsys_load_data,
    // window back end
    output cfg_header_pkg::backend_req_t be_out,
    input wire logic be_ack,
    input wire logic [31:0] be_rdata,
    // state
    output logic mem_enable
);
    // the back end offset is 20 bits wide, so no window may exceed 1 MByte
    if (REG_LOG2 < 4 || REG_LOG2 > 20 || ARR_LOG2 < 4 || ARR_LOG2 > 20) begin : g_bad_size
        $error("window size parameters out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CLAIM,
        ST_GETDATA,
        ST_BACKEND,
        ST_RESPOND,
        ST_TURN
    } tgt_state_t;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] cbe_n);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (!cbe_n[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    tgt_state_t st_q, st_d;
    cfg_header_pkg::bus_out_t out_q, out_d;
    cfg_header_pkg::backend_req_t be_q, be_d;
    cfg_header_pkg::target_kind_t kind_q, kind_d;
    logic [31:0] addr_q, addr_d;
    logic write_q, write_d;
    logic [31-REG_LOG2:0] reg_base_q, reg_base_d;
    logic [31-ARR_LOG2:0] arr_base_q, arr_base_d;
    logic [31:0] subsys_q, subsys_d;
    logic mem_en_q, mem_en_d;
    logic eep_s1_q, eep_s2_q;
    logic hit_reg, hit_arr, cfg_cmd, cfg_wr;
    logic [31:0] cfg_rd;
    logic [31:0] wr_word;

    bar_window_decode #(
        .REG_LOG2(REG_LOG2),
        .ARR_LOG2(ARR_LOG2)
    ) u_decode (
        .addr(bus_in.ad),
        .cmd(bus_in.cbe_n),
        .mem_enable(mem_en_q),
        .reg_base(reg_base_q),
        .arr_base(arr_base_q),
        .hit_reg(hit_reg),
        .hit_arr(hit_arr)
    );

    // configuration read mux; words outside this block read zero
    always_comb begin
        case (addr_q[7:2])
            cfg_header_pkg::OFF_COMMAND[7:2]: begin
                cfg_rd = cfg_header_pkg::ZERO_WORD;
                cfg_rd[cfg_header_pkg::CMD_MEM_ENABLE_BIT] = mem_en_q;
            end
            cfg_header_pkg::OFF_REG_WINDOW_BASE[7:2]:
                cfg_rd = {reg_base_q, {REG_LOG2{1'b0}}};
            cfg_header_pkg::OFF_ARRAY_WINDOW_BASE[7:2]:
                cfg_rd = {arr_base_q, {ARR_LOG2{1'b0}}};
            cfg_header_pkg::OFF_SUBSYSTEM_IDENTITY_WORD[7:2]: cfg_rd = subsys_q;
            default: cfg_rd = cfg_header_pkg::ZERO_WORD;
        endcase
    end

    // configuration register group
    always_comb begin
        cfg_wr = (st_q == ST_GETDATA) && !bus_in.irdy_n && (kind_q == cfg_header_pkg::K_CFG);
        wr_word = merge_bytes(cfg_rd, bus_in.ad, bus_in.cbe_n);
        reg_base_d = reg_base_q;
        arr_base_d = arr_base_q;
        subsys_d = subsys_q;
        mem_en_d = mem_en_q;
        if (cfg_wr) begin
            case (addr_q[7:2])
                cfg_header_pkg::OFF_COMMAND[7:2]:
                    mem_en_d = wr_word[cfg_header_pkg::CMD_MEM_ENABLE_BIT];
                cfg_header_pkg::OFF_REG_WINDOW_BASE[7:2]:
                    reg_base_d = wr_word[31:REG_LOG2];
                cfg_header_pkg::OFF_ARRAY_WINDOW_BASE[7:2]:
                    arr_base_d = wr_word[31:ARR_LOG2];
                cfg_header_pkg::OFF_SUBSYSTEM_IDENTITY_WORD[7:2]: begin
                    if (eep_s2_q) begin
                        subsys_d = wr_word;
                    end
                end
                default: begin
                end
            endcase
        end
        // a hardware load in the same cycle as a host write wins
        if (subsys_load_valid) begin
            subsys_d = subsys_load_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_base_q <= '0;
            arr_base_q <= '0;
            subsys_q <= cfg_header_pkg::SUBSYS_RESET;
            mem_en_q <= 1'b0;
            eep_s1_q <= 1'b0;
            eep_s2_q <= 1'b0;
        end else begin
            reg_base_q <= reg_base_d;
            arr_base_q <= arr_base_d;
            subsys_q <= subsys_d;
            mem_en_q <= mem_en_d;
            eep_s1_q <= external_eeprom_present;
            eep_s2_q <= eep_s1_q;
        end
    end

    // target sequencer group
    always_comb begin
        cfg_cmd = bus_in.idsel && (bus_in.ad[1:0] == 2'b00) &&
                  ((bus_in.cbe_n == cfg_header_pkg::CMD_CFG_READ) ||
                   (bus_in.cbe_n == cfg_header_pkg::CMD_CFG_WRITE));
        st_d = st_q;
        out_d = out_q;
        be_d = be_q;
        be_d.req = 1'b0;
        kind_d = kind_q;
        addr_d = addr_q;
        write_d = write_q;
        case (st_q)
            ST_IDLE: begin
                if (!bus_in.frame_n && (cfg_cmd || hit_reg || hit_arr)) begin
                    st_d = ST_CLAIM;
                    addr_d = bus_in.ad;
                    write_d = bus_in.cbe_n[0];
                    kind_d = cfg_cmd ? cfg_header_pkg::K_CFG :
                             (hit_reg ? cfg_header_pkg::K_REG : cfg_header_pkg::K_ARR);
                    out_d.devsel_n = 1'b0;
                    out_d.trdy_n = 1'b1;
                    out_d.stop_n = 1'b1;
                    out_d.ctl_oe = 1'b1;
                end
            end
            ST_CLAIM: begin
                if (write_q) begin
                    st_d = ST_GETDATA;
                end else if (kind_q == cfg_header_pkg::K_CFG) begin
                    st_d = ST_RESPOND;
                    out_d.ad = cfg_rd;
                    out_d.ad_oe = 1'b1;
                    out_d.trdy_n = 1'b0;
                    out_d.stop_n = 1'b0;
                end else begin
                    st_d = ST_BACKEND;
                    be_d.req = 1'b1;
                    be_d.write = 1'b0;
                    be_d.to_array = (kind_q == cfg_header_pkg::K_ARR);
                    be_d.addr = addr_q[19:0];
                end
            end
            ST_GETDATA: begin
                if (!bus_in.irdy_n) begin
                    if (kind_q == cfg_header_pkg::K_CFG) begin
                        st_d = ST_RESPOND;
                        out_d.trdy_n = 1'b0;
                        out_d.stop_n = 1'b0;
                    end else begin
                        st_d = ST_BACKEND;
                        be_d.req = 1'b1;
                        be_d.write = 1'b1;
                        be_d.to_array = (kind_q == cfg_header_pkg::K_ARR);
                        be_d.addr = addr_q[19:0];
                        be_d.wdata = bus_in.ad;
                    end
                end
            end
            ST_BACKEND: begin
                if (be_ack) begin
                    st_d = ST_RESPOND;
                    out_d.ad = be_rdata;
                    out_d.ad_oe = !write_q;
                    out_d.trdy_n = 1'b0;
                    out_d.stop_n = 1'b0;
                end
            end
            ST_RESPOND: begin
                // stop rides with the only data phase, so no burst continues
                if (!bus_in.irdy_n) begin
                    st_d = ST_TURN;
                    out_d.ad_oe = 1'b0;
                    out_d.devsel_n = 1'b1;
                    out_d.trdy_n = 1'b1;
                    out_d.stop_n = 1'b1;
                end
            end
            ST_TURN: begin
                st_d = ST_IDLE;
                out_d.ctl_oe = 1'b0;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            out_q <= '{ad: 32'h0000_0000, ad_oe: 1'b0, devsel_n: 1'b1, trdy_n: 1'b1,
                       stop_n: 1'b1, ctl_oe: 1'b0};
            be_q <= '0;
            kind_q <= cfg_header_pkg::K_CFG;
            addr_q <= '0;
            write_q <= 1'b0;
        end else begin
            st_q <= st_d;
            out_q <= out_d;
            be_q <= be_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            write_q <= write_d;
        end
    end

    assign bus_out = out_q;
    assign be_out = be_q;
    assign mem_enable = mem_en_q;

    // checks
    logic cfg_rd_resp;
    assign cfg_rd_resp = (st_q == ST_RESPOND) && (kind_q == cfg_header_pkg::K_CFG) && !write_q;

    a_reg_base_write: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_wr && (addr_q[7:0] == cfg_header_pkg::OFF_REG_WINDOW_BASE) && (bus_in.cbe_n == 4'h0)
        |=> reg_base_q == $past(bus_in.ad[31:REG_LOG2]))
        else $error("register window base not written");
    a_reg_base_low: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_rd_resp && (addr_q[7:0] == cfg_header_pkg::OFF_REG_WINDOW_BASE)
        |-> out_q.ad[REG_LOG2-1:4] == '0)
        else $error("register window low bits not zero");
    a_arr_base_write: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_wr && (addr_q[7:0] == cfg_header_pkg::OFF_ARRAY_WINDOW_BASE) && (bus_in.cbe_n == 4'h0)
        |=> arr_base_q == $past(bus_in.ad[31:ARR_LOG2]))
        else $error("array window base not written");
    a_arr_base_low: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_rd_resp && (addr_q[7:0] == cfg_header_pkg::OFF_ARRAY_WINDOW_BASE)
        |-> out_q.ad[ARR_LOG2-1:4] == '0)
        else $error("array window low bits not zero");
    a_base_type_bits: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_rd_resp && (addr_q[7:3] == cfg_header_pkg::OFF_REG_WINDOW_BASE[7:3])
        |-> out_q.ad[3:0] == 4'h0)
        else $error("window type bits not zero");
    a_unused_words: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_rd_resp && (addr_q[7:2] >= cfg_header_pkg::OFF_UNUSED_SLOT_TWO[7:2]) &&
        (addr_q[7:2] <= cfg_header_pkg::OFF_CARDBUS_INFO[7:2]) |-> out_q.ad == 32'h0000_0000)
        else $error("unused word reads nonzero");
    a_subsys_locked: assert property (@(posedge sys_clk) disable iff (rst)
        !eep_s2_q && !subsys_load_valid |=> $stable(subsys_q))
        else $error("subsystem identity changed without eeprom");
    a_subsys_load: assert property (@(posedge sys_clk) disable iff (rst)
        subsys_load_valid |=> subsys_q == $past(subsys_load_data))
        else $error("subsystem identity not loaded");
    a_claim_enable: assert property (@(posedge sys_clk) disable iff (rst)
        (st_q == ST_IDLE) && !bus_in.frame_n && !mem_en_q && !cfg_cmd |=> out_q.devsel_n)
        else $error("memory cycle claimed while disabled");
    a_stop_with_data: assert property (@(posedge sys_clk) disable iff (rst)
        !out_q.trdy_n |-> !out_q.stop_n)
        else $error("data phase without disconnect");
    a_single_phase: assert property (@(posedge sys_clk) disable iff (rst)
        !out_q.trdy_n && !bus_in.irdy_n |=> out_q.trdy_n && out_q.devsel_n)
        else $error("second data phase offered");
    a_claim_window: assert property (@(posedge sys_clk) disable iff (rst)
        (st_q == ST_IDLE) && !bus_in.frame_n && (hit_reg || hit_arr)
        |=> !out_q.devsel_n ##1 (be_q.req || write_q))
        else $error("matching memory cycle not claimed");

    c_cfg_write: cover property (@(posedge sys_clk) disable iff (rst) cfg_wr);
    c_reg_read: cover property (@(posedge sys_clk) disable iff (rst)
        be_q.req && !be_q.write && !be_q.to_array);
    c_arr_write: cover property (@(posedge sys_clk) disable iff (rst)
        be_q.req && be_q.write && be_q.to_array);
endmodule : cfg_base_address_block
`default_nettype wire

// ---- cfg_header_pkg.sv ----
// shared constants and carriers for the configuration header and window decode
package cfg_header_pkg;
    // configuration word byte offsets
    localparam logic [7:0] OFF_COMMAND = 8'h04;
    localparam logic [7:0] OFF_REG_WINDOW_BASE = 8'h10;
    localparam logic [7:0] OFF_ARRAY_WINDOW_BASE = 8'h14;
    localparam logic [7:0] OFF_UNUSED_SLOT_TWO = 8'h18;
    localparam logic [7:0] OFF_UNUSED_SLOT_THREE = 8'h1c;
    localparam logic [7:0] OFF_UNUSED_SLOT_FOUR = 8'h20;
    localparam logic [7:0] OFF_UNUSED_SLOT_FIVE = 8'h24;
    localparam logic [7:0] OFF_CARDBUS_INFO = 8'h28;
    localparam logic [7:0] OFF_SUBSYSTEM_IDENTITY_WORD = 8'h2c;
    // field positions and reset values
    localparam int CMD_MEM_ENABLE_BIT = 1;
    localparam int REG_WINDOW_LOG2 = 12;
    localparam int ARRAY_WINDOW_LOG2 = 20;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] SUBSYS_RESET = 32'h0000_0000;
    // bus commands
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_CFG_READ = 4'ha;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

    typedef enum logic [1:0] {
        K_CFG,
        K_REG,
        K_ARR
    } target_kind_t;

    typedef struct packed {
        logic frame_n;
        logic irdy_n;
        logic idsel;
        logic [3:0] cbe_n;
        logic [31:0] ad;
    } bus_in_t;

    typedef struct packed {
        logic [31:0] ad;
        logic ad_oe;
        logic devsel_n;
        logic trdy_n;
        logic stop_n;
        logic ctl_oe;
    } bus_out_t;

    typedef struct packed {
        logic req;
        logic write;
        logic to_array;
        logic [19:0] addr;
        logic [31:0] wdata;
    } backend_req_t;
endpackage : cfg_header_pkg

// ---- bar_window_decode.sv ----
// compares a memory cycle address against both window bases
`timescale 1ns/1ps
`default_nettype none
module bar_window_decode #(
    parameter int REG_LOG2 = 12,
    parameter int ARR_LOG2 = 20
) (
    // address and command
    input wire logic [31:0] addr,
    input wire logic [3:0] cmd,
    input wire logic mem_enable,
    // window bases
    input wire logic [31-REG_LOG2:0] reg_base,
    input wire logic [31-ARR_LOG2:0] arr_base,
    // results
    output logic hit_reg,
    output logic hit_arr
);
    logic is_mem;

    // a zero base still decodes; software is expected to program before enabling
    always_comb begin
        is_mem = (cmd == cfg_header_pkg::CMD_MEM_READ) || (cmd == cfg_header_pkg::CMD_MEM_WRITE);
        hit_reg = mem_enable && is_mem && (addr[31:REG_LOG2] == reg_base);
        hit_arr = mem_enable && is_mem && (addr[31:ARR_LOG2] == arr_base);
    end
endmodule : bar_window_decode
`default_nettype wire

// ---- bus_host_model.sv ----
// behavioural host bridge issuing single-phase configuration and memory cycles
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
    // clock
    input wire logic sys_clk,
    // bus pins
    input wire cfg_header_pkg::bus_out_t bus_out,
    output cfg_header_pkg::bus_in_t bus_in
);
    initial begin
        bus_in = '{1'b1, 1'b1, 1'b0, 4'hf, 32'h0000_0000};
    end

    // one transaction; claimed stays low on master abort
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata,
                        output logic claimed);
        int n;
        logic ready;
        rdata = ~addr;
        claimed = 1'b0;
        n = 0;
        @(negedge sys_clk);
        bus_in.frame_n = 1'b0;
        bus_in.ad = addr;
        bus_in.cbe_n = cmd;
        bus_in.idsel = (cmd == cfg_header_pkg::CMD_CFG_READ) ||
                       (cmd == cfg_header_pkg::CMD_CFG_WRITE);
        @(negedge sys_clk);
        // single data phase, whole doubleword, frame dropped with irdy
        bus_in.frame_n = 1'b1;
        bus_in.irdy_n = 1'b0;
        bus_in.cbe_n = 4'h0;
        // a read releases ad; show a changing pattern, not the old address
        bus_in.ad = cmd[0] ? wdata : ~addr;
        do begin
            @(posedge sys_clk);
            n++;
            // released control lines sit at their pull-up level
            ready = (bus_out.ctl_oe === 1'b1) && (bus_out.trdy_n === 1'b0);
        end while (!ready && n < 16);
        if (ready) begin
            claimed = 1'b1;
            if (bus_out.ad_oe === 1'b1) begin
                rdata = bus_out.ad;
            end
        end
        @(negedge sys_clk);
        bus_in.irdy_n = 1'b1;
        bus_in.idsel = 1'b0;
        bus_in.cbe_n = 4'hf;
        bus_in.ad = ~bus_in.ad;
        n = 0;
        while (bus_out.ctl_oe !== 1'b0 && n < 8) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : xfer
endmodule : bus_host_model
`default_nettype wire

// ---- cfg_base_address_block_tb_top.sv ----
// self-checking bench for the window bases, unused slots and subsystem identity
`timescale 1ns/1ps
`default_nettype none
module cfg_base_address_block_tb_top;
    typedef struct packed {
        logic [3:0] cmd;
        logic [31:0] addr;
        logic hit;
        logic arr;
    } mem_case_t;
    localparam logic [7:0] OFFS [8] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
    localparam mem_case_t CASES [6] = '{
        '{4'h6, 32'h4000_0ffc, 1'b1, 1'b0}, '{4'h6, 32'h4000_1000, 1'b0, 1'b0},
        '{4'h7, 32'h8001_2340, 1'b1, 1'b1}, '{4'h6, 32'h800f_fffc, 1'b1, 1'b1},
        '{4'h6, 32'h8010_0000, 1'b0, 1'b0}, '{4'h7, 32'h4000_0020, 1'b1, 1'b0}};
    logic sys_clk;
    logic rst;
    cfg_header_pkg::bus_in_t bus_in;
    cfg_header_pkg::bus_out_t bus_out;
    logic external_eeprom_present;
    logic subsys_load_valid;
    logic [31:0] subsys_load_data;
    cfg_header_pkg::backend_req_t be_out;
    cfg_header_pkg::backend_req_t be_cap;
    logic be_ack;
    logic [31:0] be_rdata;
    logic mem_enable;
    logic [31:0] rd;
    logic [31:0] wd;
    logic hit;
    int fails;
    int check_count;
    int stall;
    int req_count;
    int rc0;

    cfg_base_address_block #(.REG_LOG2(12), .ARR_LOG2(20)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .bus_in(bus_in), .bus_out(bus_out),
        .external_eeprom_present(external_eeprom_present),
        .subsys_load_valid(subsys_load_valid), .subsys_load_data(subsys_load_data),
        .be_out(be_out), .be_ack(be_ack), .be_rdata(be_rdata), .mem_enable(mem_enable));
    bus_host_model i_host (.sys_clk(sys_clk), .bus_out(bus_out), .bus_in(bus_in));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // back end answers each request after a programmable stall
    initial begin
        be_ack = 1'b0;
        be_rdata = 32'h0000_0000;
        req_count = 0;
        forever begin
            @(posedge sys_clk);
            if (be_out.req === 1'b1) begin
                be_cap = be_out;
                req_count++;
                repeat (stall) @(negedge sys_clk);
                @(negedge sys_clk);
                be_ack = 1'b1;
                be_rdata = {12'h0ab, be_out.addr};
                @(negedge sys_clk);
                be_ack = 1'b0;
                be_rdata = ~be_rdata;
            end
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp, input string what);
        chk32({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
    endtask : chk1

    task automatic cfg(input logic [3:0] c, input logic [7:0] off, input logic [31:0] d);
        i_host.xfer(c, {24'h00_0000, off}, d, rd, hit);
    endtask : cfg

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // the whole run is a few hundred cycles; this only cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        $display("ERROR at %0t ns: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        external_eeprom_present = 1'b0;
        subsys_load_valid = 1'b0;
        subsys_load_data = 32'h0000_0000;
        fails = 0;
        check_count = 0;
        stall = 0;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            cfg(cfg_header_pkg::CMD_CFG_READ, OFFS[i], 32'h0000_0000);
            chk32(rd, cfg_header_pkg::ZERO_WORD, "reset value");
        end
        chk1(mem_enable, 1'b0, "memory enable after reset");
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            cfg(cfg_header_pkg::CMD_CFG_WRITE, OFFS[i], 32'hffff_ffff);
            cfg(cfg_header_pkg::CMD_CFG_READ, OFFS[i], 32'h0000_0000);
            wd = (i == 0) ? 32'hffff_f000 : (i == 1) ? 32'hfff0_0000 : 32'h0000_0000;
            chk32(rd, wd, "base sizing");
        end
        $display("test base_sizing done");
        cfg(cfg_header_pkg::CMD_CFG_WRITE, 8'h2c, 32'h1357_9bdf);
        cfg(cfg_header_pkg::CMD_CFG_READ, 8'h2c, 32'h0000_0000);
        chk32(rd, 32'h0000_0000, "identity without eeprom");
        // the strap is a pin level, changed off the sampling edge
        @(negedge sys_clk);
        external_eeprom_present = 1'b1;
        repeat (3) @(negedge sys_clk);
        subsys_load_valid = 1'b1;
        subsys_load_data = 32'ha5a5_5a5a;
        @(negedge sys_clk);
        subsys_load_valid = 1'b0;
        subsys_load_data = 32'h0000_0000;
        cfg(cfg_header_pkg::CMD_CFG_READ, 8'h2c, 32'h0000_0000);
        chk32(rd, 32'ha5a5_5a5a, "identity loaded");
        cfg(cfg_header_pkg::CMD_CFG_WRITE, 8'h2c, 32'h2468_ace0);
        cfg(cfg_header_pkg::CMD_CFG_READ, 8'h2c, 32'h0000_0000);
        chk32(rd, 32'h2468_ace0, "identity host write");
        $display("test identity done");
        cfg(cfg_header_pkg::CMD_CFG_WRITE, 8'h10, 32'h4000_0000);
        cfg(cfg_header_pkg::CMD_CFG_WRITE, 8'h14, 32'h8000_0000);
        i_host.xfer(4'h6, 32'h4000_0010, 32'h0000_0000, rd, hit);
        chk1(hit, 1'b0, "claimed while disabled");
        cfg(cfg_header_pkg::CMD_CFG_WRITE, 8'h04, 32'h0000_0002);
        chk1(mem_enable, 1'b1, "memory enable set");
        for (int i = 0; i < 6; i++) begin
            stall = (i % 2) * 3;
            rc0 = req_count;
            wd = CASES[i].addr ^ 32'h5a5a_a5a5;
            i_host.xfer(CASES[i].cmd, CASES[i].addr, wd, rd, hit);
            chk1(hit, CASES[i].hit, "window claim");
            chk1(req_count == rc0 + 32'(CASES[i].hit), 1'b1, "request count");
            if (CASES[i].hit) begin
                chk1(be_cap.to_array, CASES[i].arr, "routing");
                chk32({12'h000, be_cap.addr}, {12'h000, CASES[i].addr[19:0]}, "offset");
                chk1(be_cap.write, CASES[i].cmd[0], "direction");
                if (CASES[i].cmd[0]) begin
                    chk32(be_cap.wdata, wd, "write data");
                end else begin
                    chk32(rd, {12'h0ab, CASES[i].addr[19:0]}, "read data");
                end
            end
        end
        cfg(cfg_header_pkg::CMD_CFG_WRITE, 8'h04, 32'h0000_0000);
        i_host.xfer(4'h6, 32'h4000_0000, 32'h0000_0000, rd, hit);
        chk1(hit, 1'b0, "claimed after disable");
        $display("test windows done");
        @(negedge sys_clk);
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        cfg(cfg_header_pkg::CMD_CFG_READ, 8'h10, 32'h0000_0000);
        chk32(rd, 32'h0000_0000, "base after second reset");
        chk1(mem_enable, 1'b0, "enable after second reset");
        $display("test second_reset done");
        end_of_test();
    end
endmodule : cfg_base_address_block_tb_top
`default_nettype wire
